// >>> hw/css_pkg.sv
package css_pkg;

    // Serial frame: 8 address bits then 24 data bits, LSB first
    localparam logic [5:0] CSS_FRAME_BITS = 6'h20;

    // Register addresses
    localparam logic [7:0] CSS_ADDR_LAUNCH = 8'h60;
    localparam logic [7:0] CSS_ADDR_MODE = 8'h61;
    localparam logic [7:0] CSS_ADDR_FIRST_EDGES = 8'h62;
    localparam logic [7:0] CSS_ADDR_EXPOSURE = 8'h63;
    localparam logic [7:0] CSS_ADDR_PER_FIELD = 8'h64;
    localparam logic [7:0] CSS_ADDR_MASK = 8'h65;
    localparam logic [7:0] CSS_ADDR_SECOND_EDGES = 8'h66;
    localparam logic [7:0] CSS_ADDR_SKIPPED = 8'h67;
    localparam logic [7:0] CSS_ADDR_BIAS_CFG = 8'h68;
    localparam logic [7:0] CSS_ADDR_BIAS_LINE = 8'h69;
    localparam logic [7:0] CSS_ADDR_PIN_SEL = 8'h6a;
    // Shutter n: base + 4n + {0: fields, 1: lines, 2: pixels}
    localparam logic [3:0] CSS_ADDR_SHUT_PAGE = 4'h7;

    // Launch register bit positions
    localparam int CSS_LB_ALL = 0;
    localparam int CSS_LB_BIAS_A = 4;
    localparam int CSS_LB_BIAS_B = 5;
    localparam int CSS_LB_EXPOSE = 6;
    localparam int CSS_LB_READOUT = 7;

    // Mode register bit positions
    localparam int CSS_MB_SYNC_BLANK = 3;
    localparam int CSS_MB_START_LEVEL = 4;

    // Pin selector field positions
    localparam int CSS_PS_BIAS = 0;
    localparam int CSS_PS_MECH = 4;
    localparam int CSS_PS_STROBE = 8;
    localparam int CSS_PS_TIMING = 12;
    localparam int CSS_PS_TIMING_EN = 16;

    // Reset values
    localparam logic [11:0] CSS_EDGE_OFF = 12'hfff;
    localparam logic [11:0] CSS_PER_FIELD_RST = 12'h001;

    typedef enum logic [1:0] {
        CSS_IDLE = 2'b00,
        CSS_EXPOSE = 2'b01,
        CSS_READOUT = 2'b10
    } css_phase_t;

    typedef struct packed {
        logic [2:0] rdCount;
        logic syncBlank;
        logic startLvl;
        logic [11:0] e1a;
        logic [11:0] e1b;
        logic [11:0] e2a;
        logic [11:0] e2b;
        logic [11:0] expCount;
        logic [11:0] perField;
        logic [1:0] mask;
        logic [11:0] skipped;
        logic [1:0] biasMode;
        logic [1:0] biasHold;
        logic [1:0][11:0] biasLine;
        logic [16:0] pinSel;
        logic [3:0][11:0] onFd;
        logic [3:0][11:0] offFd;
        logic [3:0][11:0] onLn;
        logic [3:0][11:0] offLn;
        logic [3:0][11:0] onPx;
        logic [3:0][11:0] offPx;
    } css_cfg_t;

    typedef struct packed {
        logic lvl;
        logic [11:0] e1a;
        logic [11:0] e1b;
        logic [11:0] e2a;
        logic [11:0] e2b;
        logic [11:0] per;
        logic [11:0] skip;
        logic [1:0] mask;
    } css_shadow_t;

endpackage

// >>> hw/css_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module css_sequencer
    import css_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic serialLoadN,
    input wire logic fieldSyncIn,
    input wire logic lineSyncIn,
    input wire logic sensorGateLine,
    output logic substrateClock,
    output logic sensorGateEnable,
    output logic fieldSyncOut,
    output logic lineSyncOut,
    output logic biasSelectPin,
    output logic mechanicalShutterPin,
    output logic strobePin,
    output logic timingPinOut,
    output logic timingPinOutEnN,
    output logic exposureBusy,
    output logic readoutBusy
);

    typedef struct packed {
        logic sckM;
        logic sckS;
        logic sckP;
        logic sdiM;
        logic sdiS;
        logic ldM;
        logic ldS;
        logic ldP;
        logic [31:0] shift;
        logic [5:0] bitCnt;
        logic [7:0] launch;
        css_cfg_t c;
        css_shadow_t a;
        css_phase_t phase;
        logic [11:0] expField;
        logic [2:0] rdField;
        logic doReadout;
        logic [11:0] pixel;
        logic [11:0] line;
        logic sgSeen;
        logic [11:0] pulseLine;
        logic tog1;
        logic tog2;
        logic [3:0] shutArm;
        logic [3:0] shutOn;
        logic [1:0] biasArm;
        logic [1:0] biasOn;
        logic subOut;
        logic sgEn;
        logic fsOut;
        logic lsOut;
        logic biasPin;
        logic mechPin;
        logic strobeOut;
        logic tpOut;
        logic tpOeN;
        logic expBusy;
        logic rdBusy;
    } css_state_t;

    css_state_t q;
    css_state_t d;

    // Sources 0-1 bias, 2-5 shutters, 6-9 shutter zero XOR bias 0, bias 1, shutter 1, shutter 2
    function automatic logic pick(input logic [3:0] sel,
                                  input logic [3:0] sh,
                                  input logic [1:0] bi);
        case (sel)
            4'h0: pick = bi[0];
            4'h1: pick = bi[1];
            4'h2: pick = sh[0];
            4'h3: pick = sh[1];
            4'h4: pick = sh[2];
            4'h5: pick = sh[3];
            4'h6: pick = sh[0] ^ bi[0];
            4'h7: pick = sh[0] ^ bi[1];
            4'h8: pick = sh[0] ^ sh[1];
            4'h9: pick = sh[0] ^ sh[2];
            default: pick = 1'b0;
        endcase
    endfunction

    always_comb begin
        logic wr;
        logic [7:0] addr;
        logic [23:0] data;
        logic [7:0] launchClr;
        logic [7:0] launchSet;
        logic seqEnd;
        logic rdStart;
        logic [1:0] idx;
        logic pulseOk;
        logic masked;
        logic blank;
        wr = 1'b0;
        addr = 8'h00;
        data = 24'h000000;
        launchClr = 8'h00;
        launchSet = 8'h00;
        seqEnd = 1'b0;
        rdStart = 1'b0;
        idx = 2'h0;
        pulseOk = 1'b0;
        masked = 1'b0;
        blank = 1'b0;
        d = q;

        // Serial port pins cross into the clock domain here
        d.sckM = serialClk;
        d.sckS = q.sckM;
        d.sckP = q.sckS;
        d.sdiM = serialData;
        d.sdiS = q.sdiM;
        d.ldM = serialLoadN;
        d.ldS = q.ldM;
        d.ldP = q.ldS;
        if (q.ldS) begin
            d.bitCnt = 6'h00;
        end else if (q.sckS && !q.sckP && q.bitCnt != CSS_FRAME_BITS) begin
            d.shift = {q.sdiS, q.shift[31:1]};
            d.bitCnt = q.bitCnt + 6'h01;
        end
        // A frame commits when at least 32 bits arrived; bits after the 32nd are ignored
        if (q.ldS && !q.ldP && q.bitCnt == CSS_FRAME_BITS) begin
            wr = 1'b1;
            addr = q.shift[7:0];
            data = q.shift[31:8];
        end

        if (wr) begin
            case (addr)
                CSS_ADDR_LAUNCH: launchSet = data[7:0];
                CSS_ADDR_MODE: begin
                    d.c.rdCount = data[2:0];
                    d.c.syncBlank = data[CSS_MB_SYNC_BLANK];
                    d.c.startLvl = data[CSS_MB_START_LEVEL];
                end
                CSS_ADDR_FIRST_EDGES: begin
                    d.c.e1a = data[11:0];
                    d.c.e1b = data[23:12];
                end
                CSS_ADDR_EXPOSURE: d.c.expCount = data[11:0];
                CSS_ADDR_PER_FIELD: d.c.perField = data[11:0];
                CSS_ADDR_MASK: d.c.mask = data[1:0];
                CSS_ADDR_SECOND_EDGES: begin
                    d.c.e2a = data[11:0];
                    d.c.e2b = data[23:12];
                end
                CSS_ADDR_SKIPPED: d.c.skipped = data[11:0];
                CSS_ADDR_BIAS_CFG: begin
                    d.c.biasMode = data[1:0];
                    d.c.biasHold = data[3:2];
                end
                CSS_ADDR_BIAS_LINE: begin
                    d.c.biasLine[0] = data[11:0];
                    d.c.biasLine[1] = data[23:12];
                end
                CSS_ADDR_PIN_SEL: d.c.pinSel = data[16:0];
                default: begin
                    if (addr[7:4] == CSS_ADDR_SHUT_PAGE) begin
                        idx = addr[3:2];
                        case (addr[1:0])
                            2'h0: begin
                                d.c.onFd[idx] = data[11:0];
                                d.c.offFd[idx] = data[23:12];
                            end
                            2'h1: begin
                                d.c.onLn[idx] = data[11:0];
                                d.c.offLn[idx] = data[23:12];
                            end
                            2'h2: begin
                                d.c.onPx[idx] = data[11:0];
                                d.c.offPx[idx] = data[23:12];
                            end
                            default: idx = 2'h0;
                        endcase
                    end
                end
            endcase
        end

        // Sequence advances only on field sync
        if (fieldSyncIn) begin
            case (q.phase)
                CSS_IDLE: begin
                    if (q.launch[CSS_LB_EXPOSE]) begin
                        d.phase = CSS_EXPOSE;
                        d.expField = 12'h000;
                        d.doReadout = q.launch[CSS_LB_READOUT];
                        d.shutArm = q.shutArm | q.launch[3:0]
                            | {4{q.launch[CSS_LB_ALL]}};
                        d.biasArm = q.biasArm
                            | q.launch[CSS_LB_BIAS_B:CSS_LB_BIAS_A];
                        launchClr = 8'hff;
                    end else if (q.launch[CSS_LB_READOUT]) begin
                        d.phase = CSS_READOUT;
                        d.rdField = 3'h0;
                        d.biasArm = q.biasArm
                            | q.launch[CSS_LB_BIAS_B:CSS_LB_BIAS_A];
                        launchClr = 8'hb0;
                        rdStart = 1'b1;
                    end
                end
                CSS_EXPOSE: begin
                    if (q.expField == q.c.expCount) begin
                        if (q.doReadout) begin
                            d.phase = CSS_READOUT;
                            d.rdField = 3'h0;
                            rdStart = 1'b1;
                        end else begin
                            d.phase = CSS_IDLE;
                            seqEnd = 1'b1;
                        end
                    end else begin
                        d.expField = q.expField + 12'h001;
                    end
                end
                CSS_READOUT: begin
                    // Readout lasts the count, at least one field
                    if ({1'b0, q.rdField} + 4'h1 >= {1'b0, q.c.rdCount}) begin
                        d.phase = CSS_IDLE;
                        seqEnd = 1'b1;
                    end else begin
                        d.rdField = q.rdField + 3'h1;
                    end
                end
                default: d.phase = CSS_IDLE;
            endcase
        end
        // A launch written during consumption survives
        d.launch = (q.launch & ~launchClr) | launchSet;

        for (int i = 0; i < 2; i++) begin
            if (q.phase == CSS_IDLE && !q.biasArm[i] && !q.c.biasHold[i]) begin
                d.biasOn[i] = 1'b0;
            end
            if (seqEnd) begin
                d.biasArm[i] = 1'b0;
                if (!q.c.biasHold[i]) begin
                    d.biasOn[i] = 1'b0;
                end
            end
            if (q.phase == CSS_EXPOSE && q.expField == 12'h000
                && q.biasArm[i] && !q.c.biasMode[i]
                && q.line == q.c.biasLine[i] && q.pixel == 12'h000) begin
                d.biasOn[i] = 1'b1;
            end
            if (rdStart && d.biasArm[i] && q.c.biasMode[i]) begin
                d.biasOn[i] = 1'b1;
            end
        end

        for (int i = 0; i < 4; i++) begin
            if (q.phase == CSS_EXPOSE && q.shutArm[i]) begin
                if (q.expField == q.c.onFd[i] && q.line == q.c.onLn[i]
                    && q.pixel == q.c.onPx[i]) begin
                    d.shutOn[i] = 1'b1;
                end
                if (q.expField == q.c.offFd[i] && q.line == q.c.offLn[i]
                    && q.pixel == q.c.offPx[i]) begin
                    d.shutOn[i] = 1'b0;
                    d.shutArm[i] = 1'b0;
                end
            end
            if (seqEnd) begin
                d.shutArm[i] = 1'b0;
            end
        end

        // Pixel and line position within the field
        if (lineSyncIn) begin
            d.pixel = 12'h000;
            d.tog1 = 1'b0;
            d.tog2 = 1'b0;
        end else if (q.pixel != 12'hfff) begin
            d.pixel = q.pixel + 12'h001;
        end
        if (fieldSyncIn) begin
            d.line = 12'h000;
        end else if (lineSyncIn) begin
            d.line = q.line + 12'h001;
        end

        if (sensorGateLine) begin
            d.sgSeen = 1'b1;
        end
        if (lineSyncIn) begin
            if (q.sgSeen) begin
                d.sgSeen = 1'b0;
                d.a.lvl = q.c.startLvl;
                d.a.e1a = q.c.e1a;
                d.a.e1b = q.c.e1b;
                d.a.e2a = q.c.e2a;
                d.a.e2b = q.c.e2b;
                d.a.per = q.c.perField;
                d.a.skip = q.c.skipped;
                d.a.mask = q.c.mask;
                d.pulseLine = 12'h001;
            end else if (q.pulseLine != 12'h000) begin
                if (q.pulseLine >= q.a.per) begin
                    d.pulseLine = 12'h000;
                end else begin
                    d.pulseLine = q.pulseLine + 12'h001;
                end
            end
        end

        pulseOk = q.pulseLine != 12'h000 && q.pulseLine > q.a.skip;
        if (!lineSyncIn && pulseOk) begin
            if (q.pixel == q.a.e1a || q.pixel == q.a.e1b) begin
                d.tog1 = ~q.tog1;
            end
            if (q.pulseLine == q.a.per
                && {q.a.e2b, q.a.e2a} != {CSS_EDGE_OFF, CSS_EDGE_OFF}
                && (q.pixel == q.a.e2a || q.pixel == q.a.e2b)) begin
                d.tog2 = ~q.tog2;
            end
        end

        case (q.a.mask)
            2'h1: masked = q.phase == CSS_EXPOSE;
            2'h2: masked = q.shutOn[3];
            default: masked = 1'b0;
        endcase
        // Suppressed fields: exposure after field 0, readout count
        if ((q.phase == CSS_EXPOSE && q.expField != 12'h000)
            || (q.phase == CSS_READOUT && q.rdField < q.c.rdCount)) begin
            masked = 1'b1;
        end
        d.subOut = masked ? q.a.lvl : q.a.lvl ^ q.tog1 ^ q.tog2;
        d.sgEn = !(q.phase == CSS_EXPOSE && q.expField != 12'h000);

        blank = q.c.syncBlank && q.phase == CSS_EXPOSE
            && q.expField != 12'h000;
        d.fsOut = fieldSyncIn && !blank;
        d.lsOut = lineSyncIn && !blank;

        d.biasPin = pick(q.c.pinSel[CSS_PS_BIAS +: 4], q.shutOn,
            q.biasOn);
        d.mechPin = pick(q.c.pinSel[CSS_PS_MECH +: 4], q.shutOn,
            q.biasOn);
        d.strobeOut = pick(q.c.pinSel[CSS_PS_STROBE +: 4], q.shutOn,
            q.biasOn);
        d.tpOut = pick(q.c.pinSel[CSS_PS_TIMING +: 4], q.shutOn,
            q.biasOn);
        d.tpOeN = !q.c.pinSel[CSS_PS_TIMING_EN];
        d.expBusy = d.phase == CSS_EXPOSE;
        d.rdBusy = d.phase == CSS_READOUT;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
            q.sckM <= 1'b0;
            q.ldM <= 1'b1;
            q.ldS <= 1'b1;
            q.ldP <= 1'b1;
            q.phase <= CSS_IDLE;
            q.c.e2a <= CSS_EDGE_OFF;
            q.c.e2b <= CSS_EDGE_OFF;
            q.c.perField <= CSS_PER_FIELD_RST;
            q.a.e2a <= CSS_EDGE_OFF;
            q.a.e2b <= CSS_EDGE_OFF;
            q.a.per <= CSS_PER_FIELD_RST;
            q.sgEn <= 1'b1;
            q.tpOeN <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign substrateClock = q.subOut;
    assign sensorGateEnable = q.sgEn;
    assign fieldSyncOut = q.fsOut;
    assign lineSyncOut = q.lsOut;
    assign biasSelectPin = q.biasPin;
    assign mechanicalShutterPin = q.mechPin;
    assign strobePin = q.strobeOut;
    assign timingPinOut = q.tpOut;
    assign timingPinOutEnN = q.tpOeN;
    assign exposureBusy = q.expBusy;
    assign readoutBusy = q.rdBusy;

endmodule

`default_nettype wire

// >>> bench/css_sync_source.sv
`timescale 1ns/1ps
`default_nettype none
// Free-running line, field and sensor-gate timing of the front end
module css_sync_source #(
    parameter int LINE = 40,
    parameter int LINES = 12,
    parameter int GATE = 2
) (
    input wire logic sys_clk,
    output logic fieldSyncIn,
    output logic lineSyncIn,
    output logic sensorGateLine
);
    int pix = 0;
    int ln = 0;
    initial begin
        fieldSyncIn = 1'h0;
        lineSyncIn = 1'h0;
        sensorGateLine = 1'h0;
    end
    always @(negedge sys_clk) begin
        pix <= (pix == LINE - 1) ? 0 : pix + 1;
        if (pix == LINE - 1) begin
            ln <= (ln == LINES - 1) ? 0 : ln + 1;
        end
        lineSyncIn <= pix == 0;
        // Mid-line field sync never shares a cycle with a line sync
        fieldSyncIn <= ln == 0 && pix == 20;
        sensorGateLine <= ln == GATE && pix >= 10 && pix < 15;
    end
endmodule
`default_nettype wire

// >>> bench/css_sequencer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module css_sequencer_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic serialLoadN,
    input wire logic fieldSyncIn,
    input wire logic lineSyncIn,
    input wire logic sensorGateLine,
    input wire logic substrateClock,
    input wire logic sensorGateEnable,
    input wire logic fieldSyncOut,
    input wire logic lineSyncOut,
    input wire logic biasSelectPin,
    input wire logic mechanicalShutterPin,
    input wire logic strobePin,
    input wire logic timingPinOut,
    input wire logic timingPinOutEnN,
    input wire logic exposureBusy,
    input wire logic readoutBusy
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    reset_idle_a: assert property (
        $fell(rst) |-> !substrateClock && sensorGateEnable && !exposureBusy
        && !readoutBusy && timingPinOutEnN)
        else $error("outputs not idle after reset");
    busy_excl_a: assert property (!(exposureBusy && readoutBusy))
        else $error("exposure and readout busy together");
    expose_edge_a: assert property (
        $changed(exposureBusy) |-> $past(fieldSyncIn))
        else $error("exposure phase moved off field sync");
    readout_edge_a: assert property (
        $changed(readoutBusy) |-> $past(fieldSyncIn))
        else $error("readout phase moved off field sync");
    field_src_a: assert property (fieldSyncOut |-> $past(fieldSyncIn))
        else $error("field sync out without field sync in");
    field_pass_a: assert property (
        fieldSyncIn && !exposureBusy |=> fieldSyncOut)
        else $error("field sync blanked outside exposure");
    line_src_a: assert property (lineSyncOut |-> $past(lineSyncIn))
        else $error("line sync out without line sync in");
    line_pass_a: assert property (
        lineSyncIn && !exposureBusy |=> lineSyncOut)
        else $error("line sync blanked outside exposure");
    gate_hold_a: assert property (
        !sensorGateEnable |-> exposureBusy || $past(exposureBusy))
        else $error("sensor gate disabled outside exposure");
    sub_quiet_a: assert property (
        !sensorGateEnable && !$past(sensorGateEnable, 2)
        |-> $stable(substrateClock))
        else $error("substrate clock moved while gate disabled");

    cover property ($rose(readoutBusy));
    cover property ($fell(exposureBusy) && readoutBusy);
    cover property (!timingPinOutEnN && timingPinOut);
    cover property ($rose(strobePin));
endmodule

bind css_sequencer css_sequencer_checker chk (
    .sys_clk(sys_clk), .rst(rst), .serialClk(serialClk),
    .serialData(serialData), .serialLoadN(serialLoadN),
    .fieldSyncIn(fieldSyncIn), .lineSyncIn(lineSyncIn),
    .sensorGateLine(sensorGateLine), .substrateClock(substrateClock),
    .sensorGateEnable(sensorGateEnable), .fieldSyncOut(fieldSyncOut),
    .lineSyncOut(lineSyncOut), .biasSelectPin(biasSelectPin),
    .mechanicalShutterPin(mechanicalShutterPin), .strobePin(strobePin),
    .timingPinOut(timingPinOut), .timingPinOutEnN(timingPinOutEnN),
    .exposureBusy(exposureBusy), .readoutBusy(readoutBusy)
);
`default_nettype wire

// >>> bench/css_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module css_sequencer_tb
    import css_pkg::*;
();
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic serialClk = 1'h0;
    logic serialData = 1'h0;
    logic serialLoadN = 1'h1;
    logic fieldSyncIn, lineSyncIn, sensorGateLine, substrateClock;
    logic sensorGateEnable, fieldSyncOut, lineSyncOut, biasSelectPin;
    logic mechanicalShutterPin, strobePin, timingPinOut, timingPinOutEnN;
    logic exposureBusy, readoutBusy;
    logic [31:0] seed = 32'ha04b;
    int errorCnt = 0;
    int checked = 0;
    int per, skip, p;
    logic hp;

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    css_sync_source src (
        .sys_clk(sys_clk), .fieldSyncIn(fieldSyncIn),
        .lineSyncIn(lineSyncIn), .sensorGateLine(sensorGateLine)
    );

    css_sequencer dut (
        .sys_clk(sys_clk), .rst(rst), .serialClk(serialClk),
        .serialData(serialData), .serialLoadN(serialLoadN),
        .fieldSyncIn(fieldSyncIn), .lineSyncIn(lineSyncIn),
        .sensorGateLine(sensorGateLine), .substrateClock(substrateClock),
        .sensorGateEnable(sensorGateEnable), .fieldSyncOut(fieldSyncOut),
        .lineSyncOut(lineSyncOut), .biasSelectPin(biasSelectPin),
        .mechanicalShutterPin(mechanicalShutterPin), .strobePin(strobePin),
        .timingPinOut(timingPinOut), .timingPinOutEnN(timingPinOutEnN),
        .exposureBusy(exposureBusy), .readoutBusy(readoutBusy)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Toggles per field: two per pulse line, two more for the extra pulse
    function automatic int nedge(input int pr, input int sk, input logic h);
        return (pr > sk) ? 2 * (pr - sk) + (h ? 2 : 0) : 0;
    endfunction

    task automatic stopTest();
        if (errorCnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic tmo(input int i);
        if (i >= 1000) begin
            errorCnt++;
            stopTest();
        end
    endtask

    task automatic chk(input string n, input logic [11:0] e,
            input logic [11:0] s);
        checked++;
        if (s !== e) begin
            errorCnt++;
            $display("ERROR %s expected %0h seen %0h", n, e, s);
        end
    endtask

    // Frame: address then data, LSB first, slow enough for the synchroniser
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        logic [31:0] f;
        f = {d, a};
        @(negedge sys_clk);
        serialLoadN = 1'h0;
        for (int i = 0; i < 32; i++) begin
            serialData = f[i];
            repeat (4) @(negedge sys_clk);
            serialClk = 1'h1;
            repeat (4) @(negedge sys_clk);
            serialClk = 1'h0;
        end
        serialLoadN = 1'h1;
        serialData = ~serialData;
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic wfs();
        int i;
        for (i = 0; i < 1000 && fieldSyncIn !== 1'h1; i++)
            @(posedge sys_clk);
        tmo(i);
    endtask

    task automatic skf();
        wfs();
        @(posedge sys_clk);
    endtask

    // Flags: exposure, readout, gate, line syncs, shutter zero, bias a
    task automatic fld(input int ed, input logic [5:0] f);
        int e, l, i;
        logic q;
        e = 0;
        l = 0;
        wfs();
        repeat (4) @(posedge sys_clk);
        #1;
        chk("exposureBusy", f[5], exposureBusy);
        chk("readoutBusy", f[4], readoutBusy);
        chk("sensorGateEnable", f[3], sensorGateEnable);
        chk("mechanicalShutterPin", f[1], mechanicalShutterPin);
        chk("biasSelectPin", f[1], biasSelectPin);
        chk("timingPinOut", f[1], timingPinOut);
        chk("strobePin", f[0], strobePin);
        q = substrateClock;
        for (i = 0; i < 1000 && fieldSyncIn !== 1'h1; i++) begin
            @(posedge sys_clk);
            #1;
            e += int'(substrateClock !== q);
            l += int'(lineSyncOut === 1'h1);
            q = substrateClock;
        end
        tmo(i);
        chk("substrate edges", 12'(ed), 12'(e));
        chk("line syncs", f[2] ? 12'h00c : 12'h000, 12'(l));
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'h0;
        repeat (4) @(negedge sys_clk);
        chk("substrateClock", 12'h000, substrateClock);
        chk("sensorGateEnable", 12'h001, sensorGateEnable);
        chk("timingPinOutEnN", 12'h001, timingPinOutEnN);
        wr(CSS_ADDR_FIRST_EDGES, 24'h00c005);
        for (int n = 1; n < 4; n++)
            wr({CSS_ADDR_SHUT_PAGE, 2'(n), 2'h0}, 24'hffffff);
        wr({CSS_ADDR_SHUT_PAGE, 4'h0}, 24'h002001);
        wr({CSS_ADDR_SHUT_PAGE, 4'h1}, 24'h004003);
        wr(CSS_ADDR_PIN_SEL, 24'h019082);
        wr(CSS_ADDR_BIAS_CFG, 24'h000001);
        chk("timingPinOutEnN", 12'h000, timingPinOutEnN);
        for (int k = 0; k < 5; k++) begin
            per = (k == 4) ? 3 : 1 + rnd() % 6;
            skip = (k == 0) ? per : (k == 4) ? 1 : rnd() % 7;
            hp = (k == 4) ? 1'h0 : 1'(rnd() % 2);
            wr(CSS_ADDR_PER_FIELD, 24'(per));
            wr(CSS_ADDR_SKIPPED, 24'(skip));
            wr(CSS_ADDR_MODE, 24'(rnd() % 2) << 4);
            wr(CSS_ADDR_MASK, 24'(k % 4));
            wr(CSS_ADDR_SECOND_EDGES, hp ? 24'h01e014 : 24'hffffff);
            skf();
            fld(nedge(per, skip, hp), 6'h0c);
        end
        p = nedge(per, skip, hp);
        wr(CSS_ADDR_MODE, 24'h00000a);
        wr(CSS_ADDR_EXPOSURE, 24'h000003);
        wfs();
        wr(CSS_ADDR_LAUNCH, 24'h0000d1);
        fld(p, 6'h2c);
        fld(0, 6'h20);
        fld(0, 6'h22);
        fld(0, 6'h20);
        fld(0, 6'h1d);
        fld(0, 6'h1d);
        fld(p, 6'h0c);
        wr(CSS_ADDR_MASK, 24'h000001);
        wr(CSS_ADDR_EXPOSURE, 24'h000000);
        wfs();
        wr(CSS_ADDR_LAUNCH, 24'h000040);
        fld(0, 6'h2c);
        fld(p, 6'h0c);
        wr(CSS_ADDR_MASK, 24'h000000);
        wr(CSS_ADDR_MODE, 24'h000003);
        wr(CSS_ADDR_BIAS_CFG, 24'h000005);
        wfs();
        wr(CSS_ADDR_LAUNCH, 24'h000090);
        for (int k = 0; k < 3; k++)
            fld(0, 6'h1d);
        fld(p, 6'h0d);
        wr(CSS_ADDR_BIAS_CFG, 24'h000001);
        fld(p, 6'h0c);
        stopTest();
    end
endmodule
`default_nettype wire
